//--- core/flash_host_pkg.sv
// package: command codes, addresses, timing and carrier types for the flash host controller
package flash_host_pkg;
	localparam int CLK_MHZ = 10;
	// bus cycle phase lengths in ns (least times, rounded up)
	localparam int T_SETUP_NS = 100;
	localparam int T_PULSE_NS = 100;
	localparam int T_HOLD_NS = 100;
	localparam int T_ACCESS_NS = 200;
	localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int PULSE_CYC = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int ACCESS_CYC = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] CNT_RESET = 4'h0;

	localparam logic [7:0] CODE_UNLOCK1 = 8'haa;
	localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
	localparam logic [7:0] CODE_AUTOSEL = 8'h90;
	localparam logic [7:0] CODE_SEC_ENTER = 8'h88;
	localparam logic [7:0] CODE_SEC_EXIT = 8'h00;
	localparam logic [7:0] CODE_PROGRAM = 8'ha0;
	localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CODE_CFI = 8'h98;
	localparam logic [7:0] CODE_RESET = 8'hf0;
	localparam logic [7:0] CODE_SUSPEND = 8'hb0;
	localparam logic [7:0] CODE_RESUME = 8'h30;
	localparam logic [7:0] LOCK_FACTORY = 8'h99;
	localparam logic [7:0] LOCK_CUSTOMER = 8'h19;

	localparam logic [21:0] ADDR_W_UNLOCK1 = 22'h000555;
	localparam logic [21:0] ADDR_W_UNLOCK2 = 22'h0002aa;
	localparam logic [21:0] ADDR_B_UNLOCK1 = 22'h000aaa;
	localparam logic [21:0] ADDR_B_UNLOCK2 = 22'h000555;
	localparam logic [21:0] ADDR_W_CFI = 22'h000055;
	localparam logic [21:0] ADDR_B_CFI = 22'h0000aa;
	localparam logic [21:0] ADDR_W_LOCK = 22'h000003;
	localparam logic [21:0] ADDR_B_LOCK = 22'h000006;
	localparam logic [21:0] ADDR_ZERO = 22'h000000;
	localparam logic [2:0] STEP_RESET = 3'h0;

	typedef enum logic [3:0] {
		CMD_RESET = 4'h0,
		CMD_READ = 4'h1,
		CMD_LOCK_QUERY = 4'h2,
		CMD_SEC_ENTER = 4'h3,
		CMD_SEC_EXIT = 4'h4,
		CMD_PROGRAM = 4'h5,
		CMD_CHIP_ERASE = 4'h6,
		CMD_SECTOR_ERASE = 4'h7,
		CMD_CFI = 4'h8,
		CMD_SUSPEND = 4'h9,
		CMD_RESUME = 4'ha,
		CMD_AUTOSEL = 4'hb
	} cmd_t;

	typedef struct packed {
		cmd_t cmd;
		logic byte_mode;
		logic [21:0] addr;
		logic [15:0] data;
	} req_t;

	typedef struct packed {
		logic we;
		logic rd;
		logic [21:0] addr;
		logic [15:0] data;
	} cyc_t;

	typedef enum logic [4:0] {
		CY_IDLE = 5'b00001,
		CY_SETUP = 5'b00010,
		CY_PULSE = 5'b00100,
		CY_HOLD = 5'b01000,
		CY_DONE = 5'b10000
	} cyc_state_t;

	typedef enum logic [3:0] {
		SQ_IDLE = 4'b0001,
		SQ_ISSUE = 4'b0010,
		SQ_WAIT = 4'b0100,
		SQ_END = 4'b1000
	} seq_state_t;
endpackage

//--- core/flash_bus_cycle.sv
// one asynchronous bus cycle on the flash pins, write or read
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle
	import flash_host_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire cyc_t cyc,
	input wire logic [15:0] dq_in,
	output logic done,
	output logic [15:0] rd_data,
	output logic ce_n,
	output logic we_n,
	output logic oe_n,
	output logic [21:0] addr,
	output logic [15:0] dq_out,
	output logic dq_oe
);
	typedef struct packed {
		cyc_state_t st;
		logic [3:0] cnt;
		logic is_rd;
		logic done;
		logic [15:0] rd_data;
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic [21:0] addr;
		logic [15:0] dq_out;
		logic dq_oe;
	} cyc_reg_t;

	cyc_reg_t r;
	cyc_reg_t next_r;
	logic [15:0] dq_s1;
	logic [15:0] dq_s2;
	logic [15:0] dq_s3;

	// =========================================
	// read data sampling
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dq_s1 <= 16'h0000;
			dq_s2 <= 16'h0000;
			dq_s3 <= 16'h0000;
		end else begin
			dq_s1 <= dq_in;
			dq_s2 <= dq_s1;
			dq_s3 <= dq_s2;
		end
	end

	// =========================================
	// cycle sequencing
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		case (r.st)
			CY_IDLE: begin
				if (start) begin
					next_r.st = CY_SETUP;
					next_r.addr = cyc.addr;
					next_r.dq_out = cyc.data;
					next_r.is_rd = cyc.rd;
					next_r.dq_oe = ~cyc.rd;
					next_r.ce_n = 1'b0;
					next_r.oe_n = 1'b1;
					next_r.cnt = CNT_RESET;
				end
			end
			CY_SETUP: begin
				next_r.cnt = r.cnt + 4'h1;
				if (r.cnt >= 4'(SETUP_CYC - 1)) begin
					next_r.st = CY_PULSE;
					next_r.cnt = CNT_RESET;
					// address latched as the later of ce/we falls
					if (r.is_rd) next_r.oe_n = 1'b0; else next_r.we_n = 1'b0;
				end
			end
			CY_PULSE: begin
				next_r.cnt = r.cnt + 4'h1;
				if (r.is_rd ? (r.cnt >= 4'(ACCESS_CYC + 1)) : (r.cnt >= 4'(PULSE_CYC - 1))) begin
					next_r.st = CY_HOLD;
					next_r.cnt = CNT_RESET;
					// take pin data only once the last two stages agree
					if (dq_s2 == dq_s3) next_r.rd_data = dq_s3;
					// we rises first so data is latched before ce releases
					next_r.we_n = 1'b1;
					next_r.oe_n = 1'b1;
				end
			end
			CY_HOLD: begin
				next_r.cnt = r.cnt + 4'h1;
				if (r.cnt >= 4'(HOLD_CYC - 1)) begin
					next_r.st = CY_DONE;
					next_r.ce_n = 1'b1;
					next_r.dq_oe = 1'b0;
				end
			end
			CY_DONE: begin
				next_r.st = CY_IDLE;
				next_r.done = 1'b1;
			end
			default: next_r.st = CY_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r <= '{st: CY_IDLE, cnt: CNT_RESET, is_rd: 1'b0, done: 1'b0, rd_data: 16'h0000,
				ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 22'h000000,
				dq_out: 16'h0000, dq_oe: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign done = r.done;
	assign rd_data = r.rd_data;
	assign ce_n = r.ce_n;
	assign we_n = r.we_n;
	assign oe_n = r.oe_n;
	assign addr = r.addr;
	assign dq_out = r.dq_out;
	assign dq_oe = r.dq_oe;
endmodule
`default_nettype wire

//--- core/flash_cmd_host.sv
// host controller issuing flash command sequences over the parallel pins
//
// Notes on behaviour
// - lock query: two unlocks, 90, then read offset 03 word or 06 byte.
// - host exits security region before touching the rest of the array; this controller does not check SEC_ACTIVE and leaves the exit to the requester.
// - unlock pair AA at 555, 55 at 2AA word; AAA, 555 byte.
// - A0 program; 80, unlock pair, 10 chip or 30 sector; 98 CFI.
// - 88 enters security; unlock, 90, 00 exits; F0 resets.
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_host
	import flash_host_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic REQ_VALID,
	input wire req_t REQ,
	output logic REQ_READY,
	output logic RESP_VALID,
	output logic [15:0] RESP_DATA,
	output logic SEC_ACTIVE,
	output logic ERASE_SUSPENDED,
	output logic FLASH_CE_N,
	output logic FLASH_WE_N,
	output logic FLASH_OE_N,
	output logic [21:0] FLASH_ADDR,
	output logic [15:0] FLASH_DQ_OUT,
	output logic FLASH_DQ_OE,
	input wire logic [15:0] FLASH_DQ_IN
);
	typedef struct packed {
		seq_state_t st;
		req_t req;
		logic [2:0] step;
		logic [2:0] last;
		logic ready;
		logic resp_valid;
		logic [15:0] resp_data;
		logic sec_active;
		logic suspended;
	} host_reg_t;

	host_reg_t r;
	host_reg_t next_r;
	logic cyc_start;
	logic cyc_done;
	cyc_t cyc;
	logic [15:0] cyc_rd;
	logic [21:0] u1;
	logic [21:0] u2;

	flash_bus_cycle u_cycle (
		.clk(REF_CLK),
		.rst(RST),
		.start(cyc_start),
		.cyc(cyc),
		.dq_in(FLASH_DQ_IN),
		.done(cyc_done),
		.rd_data(cyc_rd),
		.ce_n(FLASH_CE_N),
		.we_n(FLASH_WE_N),
		.oe_n(FLASH_OE_N),
		.addr(FLASH_ADDR),
		.dq_out(FLASH_DQ_OUT),
		.dq_oe(FLASH_DQ_OE)
	);

	// =========================================
	// number of bus cycles per command, minus one
	function automatic logic [2:0] last_step(input cmd_t c);
		case (c)
			CMD_RESET, CMD_READ, CMD_CFI, CMD_SUSPEND, CMD_RESUME: last_step = 3'h0;
			CMD_SEC_ENTER, CMD_AUTOSEL: last_step = 3'h2;
			CMD_LOCK_QUERY, CMD_SEC_EXIT, CMD_PROGRAM: last_step = 3'h3;
			CMD_CHIP_ERASE, CMD_SECTOR_ERASE: last_step = 3'h5;
			default: last_step = 3'h0;
		endcase
	endfunction

	// =========================================
	// bus cycle table per command and step
	always_comb begin
		u1 = r.req.byte_mode ? ADDR_B_UNLOCK1 : ADDR_W_UNLOCK1;
		u2 = r.req.byte_mode ? ADDR_B_UNLOCK2 : ADDR_W_UNLOCK2;
		cyc = '{we: 1'b1, rd: 1'b0, addr: u1, data: {8'h00, CODE_UNLOCK1}};
		case (r.step)
			3'h0: begin
				case (r.req.cmd)
					CMD_RESET: cyc.data = {8'h00, CODE_RESET};
					CMD_READ: cyc = '{we: 1'b0, rd: 1'b1, addr: r.req.addr, data: 16'h0000};
					CMD_CFI: begin
						cyc.addr = r.req.byte_mode ? ADDR_B_CFI : ADDR_W_CFI;
						cyc.data = {8'h00, CODE_CFI};
					end
					CMD_SUSPEND: begin
						cyc.addr = r.req.addr;
						cyc.data = {8'h00, CODE_SUSPEND};
					end
					CMD_RESUME: begin
						cyc.addr = r.req.addr;
						cyc.data = {8'h00, CODE_RESUME};
					end
					default: cyc.data = {8'h00, CODE_UNLOCK1};
				endcase
			end
			3'h1, 3'h4: begin
				cyc.addr = u2;
				cyc.data = {8'h00, CODE_UNLOCK2};
			end
			3'h2: begin
				case (r.req.cmd)
					CMD_SEC_ENTER: cyc.data = {8'h00, CODE_SEC_ENTER};
					CMD_PROGRAM: cyc.data = {8'h00, CODE_PROGRAM};
					CMD_CHIP_ERASE, CMD_SECTOR_ERASE: cyc.data = {8'h00, CODE_ERASE_SETUP};
					default: cyc.data = {8'h00, CODE_AUTOSEL};
				endcase
			end
			3'h3: begin
				case (r.req.cmd)
					CMD_LOCK_QUERY: begin
						// fourth cycle is a read of the lock code
						cyc.we = 1'b0;
						cyc.rd = 1'b1;
						cyc.addr = r.req.byte_mode ? ADDR_B_LOCK : ADDR_W_LOCK;
					end
					CMD_SEC_EXIT: begin
						cyc.addr = ADDR_ZERO;
						cyc.data = {8'h00, CODE_SEC_EXIT};
					end
					CMD_PROGRAM: begin
						cyc.addr = r.req.addr;
						cyc.data = r.req.data;
					end
					default: cyc.data = {8'h00, CODE_UNLOCK1};
				endcase
			end
			3'h5: begin
				if (r.req.cmd == CMD_SECTOR_ERASE) begin
					cyc.addr = r.req.addr;
					cyc.data = {8'h00, CODE_SECTOR_ERASE};
				end else begin
					cyc.data = {8'h00, CODE_CHIP_ERASE};
				end
			end
			default: cyc.data = {8'h00, CODE_UNLOCK1};
		endcase
	end

	// =========================================
	// sequence control
	always_comb begin
		next_r = r;
		next_r.resp_valid = 1'b0;
		cyc_start = 1'b0;
		case (r.st)
			SQ_IDLE: begin
				if (REQ_VALID && r.ready) begin
					next_r.req = REQ;
					next_r.step = STEP_RESET;
					next_r.last = last_step(REQ.cmd);
					next_r.ready = 1'b0;
					next_r.st = SQ_ISSUE;
				end
			end
			SQ_ISSUE: begin
				cyc_start = 1'b1;
				next_r.st = SQ_WAIT;
			end
			SQ_WAIT: begin
				if (cyc_done) begin
					if (r.step == r.last) begin
						next_r.st = SQ_END;
					end else begin
						next_r.step = r.step + 3'h1;
						next_r.st = SQ_ISSUE;
					end
				end
			end
			SQ_END: begin
				next_r.resp_valid = 1'b1;
				next_r.resp_data = cyc_rd;
				next_r.ready = 1'b1;
				next_r.st = SQ_IDLE;
				case (r.req.cmd)
					CMD_SEC_ENTER: next_r.sec_active = 1'b1;
					CMD_SEC_EXIT: next_r.sec_active = 1'b0;
					CMD_SUSPEND: next_r.suspended = 1'b1;
					CMD_RESUME, CMD_CHIP_ERASE, CMD_SECTOR_ERASE: next_r.suspended = 1'b0;
					CMD_RESET: next_r.suspended = r.suspended;
					default: next_r.suspended = r.suspended;
				endcase
			end
			default: next_r.st = SQ_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			r <= '{st: SQ_IDLE,
				req: '{cmd: CMD_RESET, byte_mode: 1'b0, addr: 22'h000000, data: 16'h0000},
				step: STEP_RESET, last: STEP_RESET, ready: 1'b1, resp_valid: 1'b0,
				resp_data: 16'h0000, sec_active: 1'b0, suspended: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign REQ_READY = r.ready;
	assign RESP_VALID = r.resp_valid;
	assign RESP_DATA = r.resp_data;
	assign SEC_ACTIVE = r.sec_active;
	assign ERASE_SUSPENDED = r.suspended;
endmodule
`default_nettype wire

//--- test/flash_cmd_host_asserts.sv
// checker: pin timing and handshake of the flash host controller
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_host_asserts (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic REQ_VALID,
	input wire logic REQ_READY,
	input wire logic RESP_VALID,
	input wire logic FLASH_CE_N,
	input wire logic FLASH_WE_N,
	input wire logic FLASH_OE_N,
	input wire logic [21:0] FLASH_ADDR,
	input wire logic [15:0] FLASH_DQ_OUT,
	input wire logic FLASH_DQ_OE
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// ==========
	// bus strobes
	property p_wr_strobes;
		!FLASH_WE_N |-> !FLASH_CE_N && FLASH_OE_N;
	endproperty
	a_wr_strobes: assert property (p_wr_strobes)
		else $error("write strobe without select or with output strobe");
	property p_rd_strobes;
		!FLASH_OE_N |-> FLASH_WE_N && !FLASH_DQ_OE;
	endproperty
	a_rd_strobes: assert property (p_rd_strobes)
		else $error("read overlaps a write");
	property p_wr_stable;
		!FLASH_WE_N |-> FLASH_DQ_OE && $stable(FLASH_DQ_OUT) && $stable(FLASH_ADDR);
	endproperty
	a_wr_stable: assert property (p_wr_stable)
		else $error("address or data moved during write pulse");
	property p_addr_setup;
		$fell(FLASH_WE_N) |-> !$past(FLASH_CE_N);
	endproperty
	a_addr_setup: assert property (p_addr_setup)
		else $error("write strobe fell before chip select");
	property p_we_pulse;
		$fell(FLASH_WE_N) |=> $rose(FLASH_WE_N);
	endproperty
	a_we_pulse: assert property (p_we_pulse)
		else $error("write pulse length wrong");
	property p_data_first;
		$rose(FLASH_WE_N) |-> !FLASH_CE_N ##1 FLASH_CE_N;
	endproperty
	a_data_first: assert property (p_data_first)
		else $error("chip select did not outlast write strobe");
	// ==========
	// handshake
	property p_take;
		REQ_VALID && REQ_READY |=> !REQ_READY [*3];
	endproperty
	a_take: assert property (p_take)
		else $error("ready not dropped after take");
	property p_answer;
		REQ_VALID && REQ_READY |-> ##[2:300] RESP_VALID;
	endproperty
	a_answer: assert property (p_answer)
		else $error("no response");
	property p_resp;
		RESP_VALID |-> REQ_READY ##1 !RESP_VALID;
	endproperty
	a_resp: assert property (p_resp)
		else $error("response not a single pulse with ready");
	c_read: cover property ($fell(FLASH_OE_N));
	c_write: cover property ($fell(FLASH_WE_N));
	c_resp: cover property (RESP_VALID);
endmodule
bind flash_cmd_host flash_cmd_host_asserts u_chk (.REF_CLK(REF_CLK), .RST(RST),
	.REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .RESP_VALID(RESP_VALID),
	.FLASH_CE_N(FLASH_CE_N), .FLASH_WE_N(FLASH_WE_N), .FLASH_OE_N(FLASH_OE_N),
	.FLASH_ADDR(FLASH_ADDR), .FLASH_DQ_OUT(FLASH_DQ_OUT), .FLASH_DQ_OE(FLASH_DQ_OE));
`default_nettype wire

//--- test/flash_dev_model.sv
// flash device model: command decoder, lock code, security overlay
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
	parameter bit FACTORY = 1'b1
) (
	input wire logic pwr_rst,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [21:0] addr,
	input wire logic [15:0] dq_wr,
	output logic [15:0] dq_rd,
	output logic [3:0] last_op,
	output logic sec,
	output logic susp
);
	logic [21:0] la;
	logic [2:0] st;
	logic byt, wr, erasing;
	logic [15:0] q;
	logic [21:0] u1, u2;
	assign u1 = byt ? 22'h000aaa : 22'h000555;
	assign u2 = byt ? 22'h000555 : 22'h0002aa;
	// ==========
	// command decoder
	task automatic decode(input logic [7:0] d);
		case (st)
			3'h0: begin
				if (d == 8'hf0 && !erasing) last_op = 4'h7;
				else if (d == 8'h98 && (la == 22'h55 || la == 22'haa)) last_op = 4'h4;
				else if (d == 8'hb0 && erasing && !susp) begin
					susp = 1'b1;
					last_op = 4'h9;
				end else if (d == 8'h30 && susp) begin
					susp = 1'b0;
					erasing = 1'b0;
					last_op = 4'ha;
				end else if (d == 8'haa && (la == 22'h555 || la == 22'haaa)) begin
					byt = la[3];
					st = 3'h1;
				end
			end
			3'h1: st = (d == 8'h55 && la == u2) ? 3'h2 : 3'h0;
			3'h2: begin
				st = 3'h0;
				if (la == u1 && d == 8'h88) begin
					sec = 1'b1;
					last_op = 4'h5;
				end else if (la == u1 && d == 8'h90) begin
					st = 3'h7;
					last_op = 4'h8;
				end else if (la == u1 && d == 8'ha0) st = 3'h6;
				else if (la == u1 && d == 8'h80) st = 3'h3;
			end
			3'h3: st = (d == 8'haa && la == u1) ? 3'h4 : 3'h0;
			3'h4: st = (d == 8'h55 && la == u2) ? 3'h5 : 3'h0;
			3'h5: begin
				st = 3'h0;
				if (d == 8'h10 && la == u1) last_op = 4'h2;
				else if (d == 8'h30) begin
					erasing = !(sec && FACTORY);
					last_op = erasing ? 4'h3 : 4'hb;
				end
			end
			3'h6: begin
				st = 3'h0;
				last_op = (sec && FACTORY) ? 4'hb : 4'h1;
			end
			default: begin
				if (d == 8'h00) begin
					sec = 1'b0;
					last_op = 4'h6;
					st = 3'h0;
				end else if (d == 8'hf0) begin
					last_op = 4'h7;
					st = 3'h0;
				end
			end
		endcase
	endtask
	always begin
		wait (pwr_rst);
		st = 3'h0;
		sec = 1'b0;
		susp = 1'b0;
		erasing = 1'b0;
		wr = 1'b0;
		byt = 1'b0;
		last_op = 4'h0;
		wait (!pwr_rst);
	end
	always @(negedge we_n or negedge ce_n)
		if (!we_n && !ce_n && oe_n && !pwr_rst) begin
			la = addr;
			wr = 1'b1;
		end
	always @(posedge we_n or posedge ce_n)
		if (wr) begin
			wr = 1'b0;
			decode(dq_wr[7:0]);
		end
	// ==========
	// read path, released bus shows inverse
	always @* if (!oe_n && !ce_n) begin
		if (st == 3'h7 && addr[7:0] == (byt ? 8'h06 : 8'h03)) q = FACTORY ? 16'h0099 : 16'h0019;
		else if (sec) q = {8'h5e, addr[7:0]};
		else q = addr[15:0] ^ 16'ha5a5;
	end
	assign dq_rd = (!oe_n && !ce_n) ? q : ~q;
endmodule
`default_nettype wire

//--- test/tb_top.sv
// testbench: host controller against the flash device model
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import flash_host_pkg::*;
;
	logic REF_CLK = 1'b0;
	logic RST = 1'b1;
	logic REQ_VALID = 1'b0;
	req_t REQ = '0;
	logic rdy, rv, sec_act, susp_h, ce_n, we_n, oe_n, dq_oe, msec, msusp;
	logic [15:0] rdat, dq_o, dq_i, dq_m;
	logic [21:0] fa;
	logic [3:0] op;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	always #50 REF_CLK = ~REF_CLK;
	assign dq_i = dq_oe ? dq_o : dq_m;
	flash_cmd_host dut (.REF_CLK(REF_CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ(REQ),
		.REQ_READY(rdy), .RESP_VALID(rv), .RESP_DATA(rdat), .SEC_ACTIVE(sec_act),
		.ERASE_SUSPENDED(susp_h), .FLASH_CE_N(ce_n), .FLASH_WE_N(we_n), .FLASH_OE_N(oe_n),
		.FLASH_ADDR(fa), .FLASH_DQ_OUT(dq_o), .FLASH_DQ_OE(dq_oe), .FLASH_DQ_IN(dq_i));
	flash_dev_model #(.FACTORY(1'b1)) dev (.pwr_rst(RST), .ce_n(ce_n), .we_n(we_n),
		.oe_n(oe_n), .addr(fa), .dq_wr(dq_i), .dq_rd(dq_m), .last_op(op), .sec(msec),
		.susp(msusp));
	// ==========
	// shared tasks
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge REF_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			end_sim();
		end
	end
	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic send(input cmd_t c, input logic bm, input logic [21:0] a,
		input logic [15:0] d);
		int n;
		n = 0;
		@(negedge REF_CLK);
		while (rdy !== 1'b1 && n < 500) begin
			@(negedge REF_CLK);
			n++;
		end
		REQ <= '{cmd: c, byte_mode: bm, addr: a, data: d};
		REQ_VALID <= 1'b1;
		@(negedge REF_CLK);
		REQ_VALID <= 1'b0;
		while (rv !== 1'b1 && n < 500) begin
			@(negedge REF_CLK);
			n++;
		end
		if (n >= 500) chk("response", 16'h0, 16'h1);
	endtask
	// ==========
	// scenarios
	task automatic t_reset;
		chk("reset pins", 16'({ce_n, we_n, oe_n, dq_oe, rdy, sec_act}), 16'h003a);
		chk("reset op", 16'(op), 16'h0);
	endtask
	task automatic t_table;
		cmd_t c[6] = '{CMD_RESET, CMD_CFI, CMD_PROGRAM, CMD_CHIP_ERASE, CMD_AUTOSEL, CMD_RESET};
		logic [3:0] e[6] = '{4'h7, 4'h4, 4'h1, 4'h2, 4'h8, 4'h7};
		for (int b = 0; b < 2; b++) begin
			for (int i = 0; i < 6; i++) begin
				send(c[i], b[0], 22'h001234, 16'h00c3);
				chk("op", 16'(op), 16'(e[i]));
			end
		end
	endtask
	task automatic t_lock;
		for (int b = 0; b < 2; b++) begin
			send(CMD_LOCK_QUERY, b[0], ADDR_ZERO, 16'h0);
			chk("lock code", rdat, 16'(LOCK_FACTORY));
			send(CMD_RESET, b[0], ADDR_ZERO, 16'h0);
		end
	endtask
	task automatic t_erase;
		send(CMD_SUSPEND, 1'b0, 22'h010000, 16'h0);
		chk("idle suspend", 16'({msusp, op}), 16'h0007);
		send(CMD_SECTOR_ERASE, 1'b0, 22'h010000, 16'h0);
		send(CMD_RESET, 1'b0, ADDR_ZERO, 16'h0);
		chk("reset in erase", 16'(op), 16'h0003);
		send(CMD_SUSPEND, 1'b0, 22'h010000, 16'h0);
		chk("suspend", 16'({susp_h, msusp, op}), 16'h0039);
		send(CMD_RESUME, 1'b0, 22'h010000, 16'h0);
		chk("resume", 16'({susp_h, msusp, op}), 16'h000a);
	endtask
	task automatic t_sec;
		send(CMD_SEC_ENTER, 1'b0, ADDR_ZERO, 16'h0);
		chk("enter", 16'({sec_act, msec, op}), 16'h0035);
		send(CMD_READ, 1'b0, 22'h000007, 16'h0);
		chk("serial", rdat, 16'h5e07);
		send(CMD_PROGRAM, 1'b0, 22'h000007, 16'h0012);
		chk("locked program", 16'(op), 16'h000b);
		send(CMD_RESET, 1'b0, ADDR_ZERO, 16'h0);
		send(CMD_SECTOR_ERASE, 1'b0, ADDR_ZERO, 16'h0);
		chk("locked erase", 16'(op), 16'h000b);
		send(CMD_SEC_EXIT, 1'b0, ADDR_ZERO, 16'h0);
		chk("exit", 16'({sec_act, msec, op}), 16'h0006);
		send(CMD_READ, 1'b0, 22'h000007, 16'h0);
		chk("array", rdat, 16'ha5a2);
	endtask
	task automatic t_rst;
		send(CMD_SEC_ENTER, 1'b1, ADDR_ZERO, 16'h0);
		@(negedge REF_CLK);
		RST <= 1'b1;
		repeat (2) @(negedge REF_CLK);
		RST <= 1'b0;
		chk("overlay cleared", 16'({sec_act, msec}), 16'h0);
		send(CMD_READ, 1'b1, 22'h000007, 16'h0);
		chk("boot read", rdat, 16'ha5a2);
	endtask
	initial begin
		repeat (5) @(negedge REF_CLK);
		t_reset();
		@(negedge REF_CLK);
		RST <= 1'b0;
		t_table();
		t_lock();
		t_erase();
		t_sec();
		t_rst();
		end_sim();
	end
endmodule
`default_nettype wire
